// >>> hdl/mus_params.svh
// timing counts and reset values of the multiply-unit saturation recorder
`ifndef MUS_PARAMS_SVH
`define MUS_PARAMS_SVH

// ----------------------------------------------------------------------------
// write-back latencies, in core clock cycles
// ----------------------------------------------------------------------------
`define MUS_LAT_LONG 4
`define MUS_LAT_SHORT 2
// issue spacing that makes both classes write back together
`define MUS_COLLIDE_SPACING (`MUS_LAT_LONG - `MUS_LAT_SHORT)

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define MUS_FLAG_RST 1'h0
`define MUS_PIPE_LONG_RST 4'h0
`define MUS_PIPE_SHORT_RST 2'h0

`endif

// >>> hdl/mus_pkg.sv
// types and decode functions of the multiply-unit saturation recorder
`include "mus_params.svh"

package mus_pkg;

   // -------------------------------------------------------------------------
   // instruction classes seen at a multiply unit's issue slot
   // -------------------------------------------------------------------------
   typedef enum logic [3:0] {
      MUS_OP_OTHER,                       // anything that cannot saturate
      MUS_OP_SAT_MUL_32BIT,
      MUS_OP_COMPLEX_MUL_ROUND,
      MUS_OP_COMPLEX_MUL_ROUND_ALT,
      MUS_OP_DUAL_DOT_PRODUCT_HIGH_ROUND,
      MUS_OP_DUAL_DOT_PRODUCT_LOW_ROUND,
      MUS_OP_SAT_MUL_16BIT,
      MUS_OP_SAT_MUL_LOW_HIGH,
      MUS_OP_SAT_MUL_HIGH_LOW,
      MUS_OP_SAT_SHIFT_VARIABLE_LEFT,
      MUS_OP_SAT_SHIFT_VARIABLE_RIGHT
   } mus_op_t;

   // one issue slot: valid plus instruction class
   typedef struct packed {
      logic valid;
      mus_op_t op;
   } mus_issue_t;

   // saturation detect from the arithmetic, per completing result
   typedef struct packed {
      logic sat_long;                     // long-latency result saturated
      logic sat_short;                    // short-latency result saturated
   } mus_sat_t;

   // per-unit tracking state: one-hot tokens marching to write-back
   typedef struct packed {
      logic [`MUS_LAT_LONG-1:0] pipe_long;
      logic [`MUS_LAT_SHORT-1:0] pipe_short;
   } mus_lane_state_t;

   // sticky flags of the whole recorder
   typedef struct packed {
      logic global_sat;
      logic sat_unit_two;
      logic sat_unit_one;
   } mus_flags_t;

   // long-latency saturating class
   function automatic logic mus_is_long(input mus_op_t op);
      case (op)
         MUS_OP_SAT_MUL_32BIT, MUS_OP_COMPLEX_MUL_ROUND, MUS_OP_COMPLEX_MUL_ROUND_ALT,
         MUS_OP_DUAL_DOT_PRODUCT_HIGH_ROUND, MUS_OP_DUAL_DOT_PRODUCT_LOW_ROUND: begin
            return 1'b1;
         end
         default: begin
            return 1'b0;
         end
      endcase
   endfunction : mus_is_long

   // short-latency saturating class
   function automatic logic mus_is_short(input mus_op_t op);
      case (op)
         MUS_OP_SAT_MUL_16BIT, MUS_OP_SAT_MUL_LOW_HIGH, MUS_OP_SAT_MUL_HIGH_LOW,
         MUS_OP_SAT_SHIFT_VARIABLE_LEFT, MUS_OP_SAT_SHIFT_VARIABLE_RIGHT: begin
            return 1'b1;
         end
         default: begin
            return 1'b0;
         end
      endcase
   endfunction : mus_is_short

endpackage : mus_pkg

// >>> hdl/mus_lane.sv
// per multiply unit write-back tracker and saturation merge
`timescale 1ns/100ps
`default_nettype none
`include "mus_params.svh"

module mus_lane
   import mus_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire mus_issue_t issue_i,        // issue slot of this unit
   input wire mus_sat_t sat_i,            // saturation of results completing now
   output logic wb_long_o,                // long result writes back this cycle
   output logic wb_short_o,               // short result writes back this cycle
   output logic sat_event_o               // some completing result saturated
);

   // ----------------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------------
   mus_lane_state_t state_q;              // registered tokens
   mus_lane_state_t state_d;              // next tokens

   // token shift: entry at index 0, write-back at the top index
   always_comb begin
      state_d = state_q;
      state_d.pipe_long = {state_q.pipe_long[`MUS_LAT_LONG-2:0],
                           issue_i.valid & mus_is_long(issue_i.op)};
      state_d.pipe_short = {state_q.pipe_short[`MUS_LAT_SHORT-2:0],
                            issue_i.valid & mus_is_short(issue_i.op)};
   end

   // register the copy
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q.pipe_long <= `MUS_PIPE_LONG_RST;
         state_q.pipe_short <= `MUS_PIPE_SHORT_RST;
      end else begin
         state_q <= state_d;
      end
   end

   // ----------------------------------------------------------------------------
   // merge
   // ----------------------------------------------------------------------------
   assign wb_long_o = state_q.pipe_long[`MUS_LAT_LONG-1];
   assign wb_short_o = state_q.pipe_short[`MUS_LAT_SHORT-1];
   // an or, never a priority pick: a clean long result must not hide a short one
   // a short op issued two after a long one lands in this same cycle
   assign sat_event_o = (wb_long_o & sat_i.sat_long) |
                        (wb_short_o & sat_i.sat_short);

   // ----------------------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_issue_long;
      issue_i.valid && mus_is_long(issue_i.op);
   endsequence

   sequence s_issue_short;
      issue_i.valid && mus_is_short(issue_i.op);
   endsequence

   long_latency_a: assert property (s_issue_long |-> ##4 wb_long_o)
      else $error("long saturating result not at write-back after 4 cycles");

   short_latency_a: assert property (s_issue_short |-> ##2 wb_short_o)
      else $error("short saturating result not at write-back after 2 cycles");

   collide_spacing_a: assert property (
      s_issue_long ##2 s_issue_short |-> ##2 (wb_long_o && wb_short_o))
      else $error("spacing of two did not give coincident write-back");

   short_not_masked_a: assert property (
      wb_long_o && !sat_i.sat_long && wb_short_o && sat_i.sat_short |-> sat_event_o)
      else $error("short saturation masked by clean long result");

endmodule : mus_lane

`default_nettype wire

// >>> hdl/mus_sat_status.sv
// saturation status recorder for the two multiply units of the core
//
// Overview of operation
// - saturation sets global bit and unit field
// - long class writes back after four cycles
// - short class writes back after two cycles
// - coincident write-back records either saturation
// - merge covers short issued two after long
// - each unit records its own field independently
`timescale 1ns/100ps
`default_nettype none
`include "mus_params.svh"

module mus_sat_status
   import mus_pkg::*;
(
   input wire logic CLOCK_I,
   input wire logic RESET_I,
   input wire mus_issue_t MUL_UNIT_ONE_ISSUE_I,   // issue slot, multiply unit one
   input wire mus_sat_t MUL_UNIT_ONE_SAT_I,       // saturation at write-back, unit one
   input wire mus_issue_t MUL_UNIT_TWO_ISSUE_I,   // issue slot, multiply unit two
   input wire mus_sat_t MUL_UNIT_TWO_SAT_I,       // saturation at write-back, unit two
   input wire logic CLEAR_GLOBAL_SAT_I,           // software clear of the global bit
   input wire logic CLEAR_UNIT_ONE_I,             // software clear of unit one field
   input wire logic CLEAR_UNIT_TWO_I,             // software clear of unit two field
   output logic GLOBAL_SATURATION_BIT_O,
   output logic SAT_STATUS_MUL_UNIT_ONE_O,
   output logic SAT_STATUS_MUL_UNIT_TWO_O
);

   // ----------------------------------------------------------------------------
   // per-unit trackers
   // ----------------------------------------------------------------------------
   logic ev_one;                          // unit one saturation event this cycle
   logic ev_two;                          // unit two saturation event this cycle
   logic wb_long_one;                     // unit one long write-back, checks only
   logic wb_short_one;                    // unit one short write-back, checks only
   logic wb_long_two;                     // unit two long write-back, checks only
   logic wb_short_two;                    // unit two short write-back, checks only
   // write-back strobes feed the checks only; the flags use the merged events

   // unit one: issues and write-backs only ever meet inside this lane
   mus_lane u_lane_one (
      .clk_i(CLOCK_I),
      .rst_i(RESET_I),
      .issue_i(MUL_UNIT_ONE_ISSUE_I),
      .sat_i(MUL_UNIT_ONE_SAT_I),
      .wb_long_o(wb_long_one),
      .wb_short_o(wb_short_one),
      .sat_event_o(ev_one)
   );

   // unit two: separate tracker, so cross-unit timing never interferes
   mus_lane u_lane_two (
      .clk_i(CLOCK_I),
      .rst_i(RESET_I),
      .issue_i(MUL_UNIT_TWO_ISSUE_I),
      .sat_i(MUL_UNIT_TWO_SAT_I),
      .wb_long_o(wb_long_two),
      .wb_short_o(wb_short_two),
      .sat_event_o(ev_two)
   );

   // ----------------------------------------------------------------------------
   // sticky flags
   // ----------------------------------------------------------------------------
   mus_flags_t flags_q;                   // registered flags
   mus_flags_t flags_d;                   // next flags

   // clear first, then set: an event in the clearing cycle survives
   // a clear held high lowers a flag only in cycles with no matching event
   always_comb begin
      flags_d = flags_q;
      if (CLEAR_UNIT_ONE_I) begin
         flags_d.sat_unit_one = 1'b0;
      end
      if (CLEAR_UNIT_TWO_I) begin
         flags_d.sat_unit_two = 1'b0;
      end
      if (CLEAR_GLOBAL_SAT_I) begin
         flags_d.global_sat = 1'b0;
      end
      // no path lowers a flag on a clean result, only software clears
      if (ev_one) begin
         flags_d.sat_unit_one = 1'b1;
      end
      if (ev_two) begin
         flags_d.sat_unit_two = 1'b1;
      end
      if (ev_one | ev_two) begin
         flags_d.global_sat = 1'b1;
      end
   end

   // register the copy
   always_ff @(posedge CLOCK_I) begin
      if (RESET_I) begin
         flags_q.global_sat <= `MUS_FLAG_RST;
         flags_q.sat_unit_one <= `MUS_FLAG_RST;
         flags_q.sat_unit_two <= `MUS_FLAG_RST;
      end else begin
         flags_q <= flags_d;
      end
   end

   // outputs straight from the flag flops
   assign GLOBAL_SATURATION_BIT_O = flags_q.global_sat;
   assign SAT_STATUS_MUL_UNIT_ONE_O = flags_q.sat_unit_one;
   assign SAT_STATUS_MUL_UNIT_TWO_O = flags_q.sat_unit_two;

   // ----------------------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------------------
   // one clock domain, so one default clock and one default disable
   default clocking cb @(posedge CLOCK_I); endclocking
   default disable iff (RESET_I);

   // unit one: a clean long result meets a saturated short result
   sequence s_one_collide_short_sat;
      wb_long_one && !MUL_UNIT_ONE_SAT_I.sat_long &&
         wb_short_one && MUL_UNIT_ONE_SAT_I.sat_short;
   endsequence

   // unit two: the same meeting on the other lane
   sequence s_two_collide_short_sat;
      wb_long_two && !MUL_UNIT_TWO_SAT_I.sat_long &&
         wb_short_two && MUL_UNIT_TWO_SAT_I.sat_short;
   endsequence

   // unit two saturates alone while the unit one field is clear
   sequence s_two_alone_one_clear;
      ev_two && !ev_one && !SAT_STATUS_MUL_UNIT_ONE_O;
   endsequence

   // unit one saturates alone while the unit two field is clear
   sequence s_one_alone_two_clear;
      ev_one && !ev_two && !SAT_STATUS_MUL_UNIT_TWO_O;
   endsequence

   // a unit one event raises its field and the global bit
   set_on_sat_a: assert property (
      ev_one |=> SAT_STATUS_MUL_UNIT_ONE_O && GLOBAL_SATURATION_BIT_O)
      else $error("unit one saturation not recorded");

   // a unit two event raises its field and the global bit
   set_unit_two_a: assert property (
      ev_two |=> SAT_STATUS_MUL_UNIT_TWO_O && GLOBAL_SATURATION_BIT_O)
      else $error("unit two saturation not recorded");

   // coincident write-back on unit one keeps the short saturation
   collide_record_a: assert property (
      s_one_collide_short_sat |=> SAT_STATUS_MUL_UNIT_ONE_O)
      else $error("coincident short saturation lost in unit one field");

   // coincident write-back on unit two keeps the short saturation
   collide_two_a: assert property (
      s_two_collide_short_sat |=> SAT_STATUS_MUL_UNIT_TWO_O)
      else $error("coincident short saturation lost in unit two field");

   // a unit two event never reaches the unit one field
   units_apart_a: assert property (
      s_two_alone_one_clear |=> SAT_STATUS_MUL_UNIT_TWO_O && !SAT_STATUS_MUL_UNIT_ONE_O)
      else $error("unit two event leaked into unit one field");

   // a unit one event never reaches the unit two field
   units_apart_two_a: assert property (
      s_one_alone_two_clear |=> SAT_STATUS_MUL_UNIT_ONE_O && !SAT_STATUS_MUL_UNIT_TWO_O)
      else $error("unit one event leaked into unit two field");

   // unit one field holds until its clear
   flag_sticky_a: assert property (
      SAT_STATUS_MUL_UNIT_ONE_O && !CLEAR_UNIT_ONE_I |=> SAT_STATUS_MUL_UNIT_ONE_O)
      else $error("unit one flag dropped without a clear");

   // unit two field holds until its clear
   sticky_two_a: assert property (
      SAT_STATUS_MUL_UNIT_TWO_O && !CLEAR_UNIT_TWO_I |=> SAT_STATUS_MUL_UNIT_TWO_O)
      else $error("unit two flag dropped without a clear");

   // global bit holds until its clear
   global_sticky_a: assert property (
      GLOBAL_SATURATION_BIT_O && !CLEAR_GLOBAL_SAT_I |=> GLOBAL_SATURATION_BIT_O)
      else $error("global bit dropped without a clear");

   // a unit two event in the clearing cycle of its field wins
   set_beats_clear_a: assert property (
      ev_two && CLEAR_UNIT_TWO_I |=> SAT_STATUS_MUL_UNIT_TWO_O)
      else $error("unit two event lost to a clear in the same cycle");

   // an event in the clearing cycle of the global bit wins
   global_set_wins_a: assert property (
      (ev_one || ev_two) && CLEAR_GLOBAL_SAT_I |=> GLOBAL_SATURATION_BIT_O)
      else $error("global event lost to a clear in the same cycle");

   // a clear with no event lowers the unit one field
   clear_one_a: assert property (
      CLEAR_UNIT_ONE_I && !ev_one |=> !SAT_STATUS_MUL_UNIT_ONE_O)
      else $error("unit one clear did not lower the field");

   // a clear with no event lowers the unit two field
   clear_two_a: assert property (
      CLEAR_UNIT_TWO_I && !ev_two |=> !SAT_STATUS_MUL_UNIT_TWO_O)
      else $error("unit two clear did not lower the field");

   // a clear with no event lowers the global bit
   clear_global_a: assert property (
      CLEAR_GLOBAL_SAT_I && !ev_one && !ev_two |=> !GLOBAL_SATURATION_BIT_O)
      else $error("global clear did not lower the bit");

   // only a unit one event raises the unit one field
   no_false_one_a: assert property (
      !SAT_STATUS_MUL_UNIT_ONE_O && !ev_one |=> !SAT_STATUS_MUL_UNIT_ONE_O)
      else $error("unit one field rose without an event");

   // only a unit two event raises the unit two field
   no_false_two_a: assert property (
      !SAT_STATUS_MUL_UNIT_TWO_O && !ev_two |=> !SAT_STATUS_MUL_UNIT_TWO_O)
      else $error("unit two field rose without an event");

   // only an event of either unit raises the global bit
   no_false_global_a: assert property (
      !GLOBAL_SATURATION_BIT_O && !ev_one && !ev_two |=> !GLOBAL_SATURATION_BIT_O)
      else $error("global bit rose without an event");

endmodule : mus_sat_status

`default_nettype wire

// >>> testbench/mus_sat_status_tb.sv
// self-checking bench of the multiply-unit saturation recorder
`timescale 1ns/100ps
`default_nettype none
`include "mus_params.svh"
// compare, count and report one value
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin n_fail++; \
   $display("BAD t=%0t got=%h exp=%h", $time, got, exp); end end

module mus_sat_status_tb
   import mus_pkg::*;
;
   // ----------------------------------------------------------------------
   // stimulus and observation
   // ----------------------------------------------------------------------
   logic clk = 1'b0;                   // core clock, 100 MHz
   logic rst = 1'b1;                   // synchronous reset, held at start
   mus_issue_t iss [2] = '{default: '0}; // issue slots, index 0 is unit one
   mus_sat_t sat [2] = '{default: '0};  // saturation at write-back
   logic clr_g = 1'b0;                 // clear of the global bit
   logic clr_1 = 1'b0;                 // clear of unit one field
   logic clr_2 = 1'b0;                 // clear of unit two field
   logic glob, st1, st2;               // flags under test
   int n_fail = 0;                     // mismatches so far
   int total_checks = 0;               // comparisons so far
   int cycles = 0;                     // hang guard
   mus_op_t long_ops [5] = '{MUS_OP_SAT_MUL_32BIT, MUS_OP_COMPLEX_MUL_ROUND,
      MUS_OP_COMPLEX_MUL_ROUND_ALT, MUS_OP_DUAL_DOT_PRODUCT_HIGH_ROUND,
      MUS_OP_DUAL_DOT_PRODUCT_LOW_ROUND};
   mus_op_t short_ops [5] = '{MUS_OP_SAT_MUL_16BIT, MUS_OP_SAT_MUL_LOW_HIGH,
      MUS_OP_SAT_MUL_HIGH_LOW, MUS_OP_SAT_SHIFT_VARIABLE_LEFT,
      MUS_OP_SAT_SHIFT_VARIABLE_RIGHT};

   always #5 clk = ~clk;               // half period of 5 ns

   mus_sat_status dut (
      .CLOCK_I(clk),
      .RESET_I(rst),
      .MUL_UNIT_ONE_ISSUE_I(iss[0]),
      .MUL_UNIT_ONE_SAT_I(sat[0]),
      .MUL_UNIT_TWO_ISSUE_I(iss[1]),
      .MUL_UNIT_TWO_SAT_I(sat[1]),
      .CLEAR_GLOBAL_SAT_I(clr_g),
      .CLEAR_UNIT_ONE_I(clr_1),
      .CLEAR_UNIT_TWO_I(clr_2),
      .GLOBAL_SATURATION_BIT_O(glob),
      .SAT_STATUS_MUL_UNIT_ONE_O(st1),
      .SAT_STATUS_MUL_UNIT_TWO_O(st2)
   );

   // ----------------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------------
   // counts, verdict and end of run
   task automatic stop_test();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : stop_test

   // issue one op, raise saturation (if s) at cycle 'at' after the issue edge,
   // optionally clear all flags in that same cycle, then check the flags
   task automatic run_op(input int u, input mus_op_t op, input logic lng, input int at,
      input logic s, input logic clr, input logic [2:0] exp);
      @(posedge clk);
      iss[u] <= '{valid: 1'b1, op: op};
      @(posedge clk);
      iss[u] <= '0;
      repeat (at - 1) @(posedge clk);
      if (lng) begin
         sat[u].sat_long <= s;
      end else begin
         sat[u].sat_short <= s;
      end
      {clr_g, clr_1, clr_2} <= {3{clr}};
      @(posedge clk);
      sat[u] <= '0;
      {clr_g, clr_1, clr_2} <= 3'h0;
      #1;
      `CHK({glob, st1, st2}, exp)
   endtask : run_op

   // clear every flag and let any token still in flight drain
   task automatic clear_all();
      @(posedge clk);
      {clr_g, clr_1, clr_2} <= 3'h7;
      @(posedge clk);
      {clr_g, clr_1, clr_2} <= 3'h0;
      repeat (`MUS_LAT_LONG) @(posedge clk);
      #1;
      `CHK({glob, st1, st2}, 3'h0)
   endtask : clear_all

   // long op on unit ul, short op on unit us two cycles later: same write-back
   task automatic t_pair(input int ul, input int us, input logic sl, input logic ss,
      input logic [2:0] exp);
      @(posedge clk);
      iss[ul] <= '{valid: 1'b1, op: MUS_OP_COMPLEX_MUL_ROUND};
      @(posedge clk);
      iss[ul] <= '0;
      @(posedge clk);
      iss[us] <= '{valid: 1'b1, op: MUS_OP_SAT_SHIFT_VARIABLE_LEFT};
      @(posedge clk);
      iss[us] <= '0;
      @(posedge clk);
      sat[ul].sat_long <= sl;
      sat[us].sat_short <= ss;
      @(posedge clk);
      sat[0] <= '0;
      sat[1] <= '0;
      #1;
      `CHK({glob, st1, st2}, exp)
      clear_all();
   endtask : t_pair

   // ----------------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------------
   // every saturating op on both units at its write-back cycle, and two ops off it
   // lone issues never meet at write-back, as code generators arrange
   task automatic t_ops();
      for (int u = 0; u < 2; u++) begin
         for (int i = 0; i < 5; i++) begin
            run_op(u, long_ops[i], 1'b1, `MUS_LAT_LONG, 1'b1, 1'b0,
               u ? 3'h5 : 3'h6);
            clear_all();
            run_op(u, short_ops[i], 1'b0, `MUS_LAT_SHORT, 1'b1, 1'b0,
               u ? 3'h5 : 3'h6);
            clear_all();
         end
      end
      // saturation a cycle early or late, or on a non-saturating op, is not a write-back
      run_op(0, long_ops[0], 1'b1, `MUS_LAT_LONG - 1, 1'b1, 1'b0, 3'h0);
      clear_all();
      run_op(1, short_ops[4], 1'b0, `MUS_LAT_SHORT + 1, 1'b1, 1'b0, 3'h0);
      clear_all();
      run_op(0, MUS_OP_OTHER, 1'b0, `MUS_LAT_SHORT, 1'b1, 1'b0, 3'h0);
      clear_all();
      $display("test ops done");
   endtask : t_ops

   // coincident write-back on one unit and across units
   task automatic t_merge();
      t_pair(0, 0, 1'b0, 1'b1, 3'h6);
      t_pair(1, 1, 1'b1, 1'b0, 3'h5);
      t_pair(1, 1, 1'b0, 1'b1, 3'h5);
      t_pair(0, 0, 1'b0, 1'b0, 3'h0);
      t_pair(1, 0, 1'b0, 1'b1, 3'h6);
      t_pair(0, 1, 1'b0, 1'b1, 3'h5);
      t_pair(0, 1, 1'b1, 1'b1, 3'h7);
      $display("test merge done");
   endtask : t_merge

   // flags hold until cleared; a set beats a clear in the same cycle
   task automatic t_sticky();
      run_op(0, short_ops[1], 1'b0, `MUS_LAT_SHORT, 1'b1, 1'b0, 3'h6);
      run_op(0, long_ops[3], 1'b1, `MUS_LAT_LONG, 1'b0, 1'b0, 3'h6);
      @(posedge clk);
      clr_g <= 1'b1;
      @(posedge clk);
      clr_g <= 1'b0;
      #1;
      `CHK({glob, st1, st2}, 3'h2)
      run_op(1, long_ops[2], 1'b1, `MUS_LAT_LONG, 1'b1, 1'b1, 3'h5);
      clear_all();
      $display("test sticky done");
   endtask : t_sticky

   // ----------------------------------------------------------------------
   // main sequence and hang guard
   // ----------------------------------------------------------------------
   // the whole run is well under a thousand cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         n_fail++;
         stop_test();
      end
   end

   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      #1;
      `CHK({glob, st1, st2}, 3'h0)
      $display("test reset done");
      t_ops();
      t_merge();
      t_sticky();
      stop_test();
   end

endmodule : mus_sat_status_tb
`default_nettype wire
